// file: asi_node_cfg.svh
// timing counts, register offsets and reset values for the bus node core
`ifndef ASI_NODE_CFG_SVH
`define ASI_NODE_CFG_SVH
`define MCLK_MHZ 100
`define HALF_BIT_NS 3000
`define HALF_BIT_CYC (`HALF_BIT_NS * `MCLK_MHZ / 1000)
`define WDOG_NS 20000
`define WDOG_CYC (`WDOG_NS * `MCLK_MHZ / 1000)
`define DETECT_US 200
`define DETECT_CYC (`DETECT_US * `MCLK_MHZ)
`define HOT_MS 2000
`define HOT_CYC (`HOT_MS * `MCLK_MHZ * 1000)
`define TICK_THR 150
`define THR_RESET 3'h2
`define MC_BITS 14
`define SR_BITS 7
`define REG_STATUS 8'h00
`define REG_RXDATA 8'h04
`define REG_RESP 8'h08
`define REG_THRESH 8'h0C
`endif

// file: asi_node_pkg.sv
// types shared by the bus node core
package asi_node_pkg;
    typedef enum logic [1:0] {
        MODE_SLAVE = 2'b00,
        MODE_MASTER = 2'b01,
        MODE_REPEATER = 2'b11,
        MODE_MONITOR = 2'b10
    } mode_type;
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_REPLY = 2'b01,
        MS_SEND = 2'b11
    } main_state_type;
    typedef struct packed {
        logic bit_valid;
        logic bit_value;
        logic frame_end;
        logic timing_err;
    } rx_bits_type;
endpackage : asi_node_pkg

// file: asi_node_core.sv
// digital core of a two-wire sensor bus node
`timescale 1ns/1ps
`default_nettype none
`include "asi_node_cfg.svh"
// Summary of operation
// - first pulse level sets half-level thresholds
// - memory writes and I/O only in slave
// - slave mode strobes only checked telegrams
// - decode call, wait reply data from software
// - reply sent as Manchester-II stream
// - start at 16 MHz, decide after 200us
// - detection frozen after first good call, or any good telegram outside slave
// - missing clock over 20us forces reset
// - 2s overheat shuts inductor, resets, powers down
// - shutdown latched until supply cycled
// - load output short acts like overheat
// - aux pin: slave channel, master transmit input
// - fail pin analog in master, else digital
// - mode from master and repeater flags
// - flags read at init, mode then fixed
// - master mode checks telegrams before strobing
// - master one strobe, monitor two strobes
// - slave locks on call, others any telegram
// - watchdog reset holds until clock returns
module asi_node_core
    import asi_node_pkg::*;
#(
    parameter int DETECT_CYC = `DETECT_CYC,
    parameter int HOT_CYC = `HOT_CYC,
    parameter int WDOG_CYC = `WDOG_CYC,
    parameter int TICK_THR = `TICK_THR
) (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // non-volatile mode flags
    input wire logic nv_master_flag,
    input wire logic nv_repeater_flag,
    // receive front end
    input wire logic [2:0] adc_level,
    input wire logic first_pulse,
    output logic [2:0] thr_pos,
    output logic [2:0] thr_neg,
    input wire rx_bits_type bus_rx,
    input wire rx_bits_type aux_rx,
    input wire logic aux_address_input,
    // transmit unit
    output logic tx_drive,
    output logic tx_active,
    // receive strobes
    output logic master_strobe,
    output logic slave_strobe,
    // clock, protection and pin setup
    input wire logic xtal_tick,
    input wire logic over_temp,
    input wire logic load_short,
    output logic freq_16mhz,
    output logic freq_locked,
    output logic device_reset,
    output logic inductor_enable,
    output logic analog_power_down,
    output logic fail_detect_analog,
    output logic nv_write_enable
);
    localparam int DW = $clog2(DETECT_CYC + 1);
    localparam int HW = $clog2(HOT_CYC + 1);
    localparam int WW = $clog2(WDOG_CYC + 1);
    localparam int BW = $clog2(`HALF_BIT_CYC + 1);

    logic core_rst_ff, init_ff, shut_ff, locked_ff, freq16_ff, tx_ff;
    logic master_strobe_ff, slave_strobe_ff, rx_new_ff, rx_chan_ff;
    logic pready_ff, pslverr_ff;
    logic [2:0] thr_pos_ff, thr_neg_ff;
    logic [10:0] rx_info_ff;
    logic [3:0] sr_last_ff, resp_ff, bit_idx_ff;
    logic [31:0] prdata_ff;
    logic [DW-1:0] win_ff;
    logic [15:0] tick_ff;
    logic [WW-1:0] gap_ff;
    logic [HW-1:0] hot_ff;
    logic [BW-1:0] hb_ff;
    mode_type mode_ff;
    main_state_type state_ff;
    logic wdog_rst, resp_wr, rx_rd;

    wire logic rst_any = reset | core_rst_ff;
    wire logic run = ~rst_any & ~init_ff;
    wire logic is_slave = mode_ff == MODE_SLAVE;
    wire logic is_master = mode_ff == MODE_MASTER;
    wire logic is_monitor = mode_ff == MODE_MONITOR;

    // internal reset from watchdog or shutdown
    always_ff @(posedge mclk) begin
        core_rst_ff <= reset | wdog_rst | shut_ff;
        init_ff <= rst_any;
    end

    wire mode_type nv_mode = mode_type'({nv_repeater_flag, nv_master_flag});
    always_ff @(posedge mclk) begin
        if (reset)
            mode_ff <= MODE_SLAVE;
        else if (init_ff & ~core_rst_ff)
            mode_ff <= nv_mode;
    end

    wire logic [3:0] adc_round = {1'b0, adc_level} + 4'h1;
    wire logic [2:0] thr_new = adc_round[3:1];
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            thr_pos_ff <= `THR_RESET;
            thr_neg_ff <= `THR_RESET;
        end else if (first_pulse) begin
            thr_pos_ff <= thr_new;
            thr_neg_ff <= thr_new;
        end
    end

    // telegram checkers, bus channel and aux channel
    rx_bits_type rx_ch [2];
    wire logic [1:0] mc_ok, sr_ok;
    logic [10:0] mc_info [2];
    logic [3:0] sr_info [2];
    assign rx_ch[0] = bus_rx;
    assign rx_ch[1] = aux_rx;
    for (genvar g = 0; g < 2; g++) begin : g_chk
        logic [13:0] sh_ff;
        logic [3:0] cnt_ff;
        logic err_ff;
        // aux channel is not a receiver in master mode
        wire logic en = run & ((g == 0) | ~is_master);
        wire logic good = en & rx_ch[g].frame_end & ~err_ff & ~rx_ch[g].timing_err;
        always_ff @(posedge mclk) begin
            if (rst_any | rx_ch[g].frame_end) begin
                sh_ff <= 14'h0000;
                cnt_ff <= 4'h0;
                err_ff <= 1'b0;
            end else begin
                err_ff <= err_ff | rx_ch[g].timing_err;
                if (rx_ch[g].bit_valid) begin
                    sh_ff <= {sh_ff[12:0], rx_ch[g].bit_value};
                    cnt_ff <= (cnt_ff == 4'hF) ? cnt_ff : cnt_ff + 4'h1;
                end
            end
        end
        assign mc_ok[g] = good & (cnt_ff == 4'(`MC_BITS)) & ~sh_ff[13] & sh_ff[0] & ~^sh_ff[12:1];
        assign sr_ok[g] = good & (cnt_ff == 4'(`SR_BITS)) & ~sh_ff[6] & sh_ff[0] & ~^sh_ff[5:1];
        assign mc_info[g] = sh_ff[12:2];
        assign sr_info[g] = sh_ff[5:2];
    end
    wire logic any_mc = |mc_ok;
    wire logic any_sr = |sr_ok;
    wire logic sel_aux = ~(mc_ok[0] | sr_ok[0]);

    always_ff @(posedge mclk) begin
        // call strobe in slave and monitor
        master_strobe_ff <= any_mc & (is_slave | is_monitor);
        // response strobe in master and monitor
        slave_strobe_ff <= any_sr & (is_master | is_monitor);
    end

    always_ff @(posedge mclk) begin
        if (reset)
            locked_ff <= 1'b0;
        else if (any_mc | (any_sr & ~is_slave))
            locked_ff <= 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            win_ff <= '0;
            tick_ff <= 16'h0000;
            freq16_ff <= 1'b1;
        end else if (~locked_ff) begin
            if (win_ff == DW'(DETECT_CYC - 1)) begin
                win_ff <= '0;
                tick_ff <= 16'h0000;
                freq16_ff <= tick_ff >= 16'(TICK_THR);
            end else begin
                win_ff <= win_ff + DW'(1);
                tick_ff <= tick_ff + {15'h0000, xtal_tick};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset | xtal_tick)
            gap_ff <= '0;
        else if (~wdog_rst)
            gap_ff <= gap_ff + WW'(1);
    end
    assign wdog_rst = gap_ff >= WW'(WDOG_CYC);

    always_ff @(posedge mclk) begin
        if (reset) begin
            hot_ff <= '0;
            shut_ff <= 1'b0;
        end else begin
            hot_ff <= ((over_temp | load_short) & ~shut_ff) ? hot_ff + HW'(1) : '0;
            if (hot_ff == HW'(HOT_CYC - 1))
                shut_ff <= 1'b1;
        end
    end

    // main state machine and reply encoder
    wire logic [6:0] frame = {1'b0, resp_ff, ^resp_ff, 1'b1};
    wire logic [2:0] fb = 3'h6 - bit_idx_ff[3:1];
    wire logic cur_bit = frame[fb];
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            state_ff <= MS_IDLE;
            hb_ff <= '0;
            bit_idx_ff <= 4'h0;
        end else begin
            case (state_ff)
                // decoded call waits for reply data
                MS_IDLE: if (is_slave & any_mc) state_ff <= MS_REPLY;
                MS_REPLY: if (resp_wr) state_ff <= MS_SEND;
                MS_SEND: begin
                    if (hb_ff == BW'(`HALF_BIT_CYC - 1)) begin
                        hb_ff <= '0;
                        bit_idx_ff <= bit_idx_ff + 4'h1;
                        if (bit_idx_ff == 4'(2 * `SR_BITS - 1)) begin
                            bit_idx_ff <= 4'h0;
                            state_ff <= MS_IDLE;
                        end
                    end else begin
                        hb_ff <= hb_ff + BW'(1);
                    end
                end
                default: state_ff <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_any)
            tx_ff <= 1'b0;
        // aux pin keys transmitter in master mode
        else if (is_master)
            tx_ff <= aux_address_input;
        else
            tx_ff <= (state_ff == MS_SEND) & (bit_idx_ff[0] ? cur_bit : ~cur_bit);
    end

    // received data and reply register
    always_ff @(posedge mclk) begin
        if (rst_any) begin
            rx_info_ff <= 11'h000;
            sr_last_ff <= 4'h0;
            rx_new_ff <= 1'b0;
            rx_chan_ff <= 1'b0;
            resp_ff <= 4'h0;
        end else begin
            if (any_mc)
                rx_info_ff <= mc_info[sel_aux];
            if (any_sr)
                sr_last_ff <= sr_info[sel_aux];
            if (any_mc | any_sr)
                rx_chan_ff <= sel_aux;
            // new telegram wins over read clear
            rx_new_ff <= any_mc | any_sr | (rx_new_ff & ~rx_rd);
            if (resp_wr)
                resp_ff <= pwdata[3:0];
        end
    end

    // apb decode, one wait state
    wire logic hit_status = paddr == {24'h000000, `REG_STATUS};
    wire logic hit_rx = paddr == {24'h000000, `REG_RXDATA};
    wire logic hit_resp = paddr == {24'h000000, `REG_RESP};
    wire logic hit_thr = paddr == {24'h000000, `REG_THRESH};
    wire logic mapped = hit_status | hit_rx | hit_resp | hit_thr;
    wire logic acc = psel & penable;
    wire logic done = acc & pready_ff;
    // reply data only in slave mode
    wire logic refuse = pwrite & hit_resp & ~(is_slave & (state_ff == MS_REPLY));
    assign resp_wr = done & pwrite & hit_resp & ~pslverr_ff;
    assign rx_rd = done & ~pwrite & hit_rx;
    wire logic [31:0] rd_mux =
        hit_status ? {24'h000000, state_ff, shut_ff, wdog_rst, locked_ff, freq16_ff, mode_ff} :
        hit_rx ? {15'h0000, rx_chan_ff, rx_new_ff, sr_last_ff, rx_info_ff} :
        hit_resp ? {28'h0000000, resp_ff} :
        hit_thr ? {25'h0000000, thr_neg_ff, 1'b0, thr_pos_ff} : 32'h00000000;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= acc & ~pready_ff;
            if (acc & ~pready_ff) begin
                pslverr_ff <= ~mapped | refuse;
                prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff & pready_ff;
    assign thr_pos = thr_pos_ff;
    assign thr_neg = thr_neg_ff;
    assign tx_drive = tx_ff;
    assign tx_active = (state_ff == MS_SEND) | (run & is_master);
    assign master_strobe = master_strobe_ff;
    assign slave_strobe = slave_strobe_ff;
    assign freq_16mhz = freq16_ff;
    assign freq_locked = locked_ff;
    assign device_reset = core_rst_ff;
    assign inductor_enable = ~shut_ff;
    assign analog_power_down = shut_ff;
    assign fail_detect_analog = run & is_master;
    assign nv_write_enable = run & is_slave;

    property p_thr;
        @(posedge mclk) disable iff (reset) first_pulse && !rst_any |=> thr_pos_ff == $past(thr_new) && thr_neg_ff == thr_pos_ff;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold not half level");
    property p_resp_slave;
        @(posedge mclk) disable iff (reset) resp_wr |-> is_slave && state_ff == MS_REPLY;
    endproperty
    a_resp_slave: assert property (p_resp_slave) else $error("reply accepted outside slave reply");
    property p_strobe;
        @(posedge mclk) disable iff (reset) master_strobe_ff |-> $past(any_mc) && !$past(rst_any);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe without checked telegram");
    property p_reply;
        @(posedge mclk) disable iff (reset) state_ff == MS_REPLY && resp_wr && !rst_any |=> state_ff == MS_SEND;
    endproperty
    a_reply: assert property (p_reply) else $error("reply write did not start send");
    property p_manchester;
        @(posedge mclk) disable iff (reset) $rose(state_ff == MS_SEND) |=> tx_ff ##300 !tx_ff;
    endproperty
    a_manchester: assert property (p_manchester) else $error("start bit halves wrong");
    property p_freq_default;
        @(posedge mclk) disable iff (reset) $past(reset) |-> freq16_ff;
    endproperty
    a_freq_default: assert property (p_freq_default) else $error("not 16 MHz after power-on");
    property p_freeze;
        @(posedge mclk) disable iff (reset) locked_ff && $past(locked_ff) |-> $stable(freq16_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frequency changed after lock");
    property p_wdog;
        @(posedge mclk) disable iff (reset) gap_ff == WW'(WDOG_CYC) && !xtal_tick |=> core_rst_ff [*2];
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
    property p_hot;
        @(posedge mclk) disable iff (reset) hot_ff == HW'(HOT_CYC - 1) |=> shut_ff ##1 core_rst_ff && !inductor_enable;
    endproperty
    a_hot: assert property (p_hot) else $error("overheat shutdown missing");
    property p_latch;
        @(posedge mclk) disable iff (reset) shut_ff |=> shut_ff && analog_power_down;
    endproperty
    a_latch: assert property (p_latch) else $error("shutdown released");
    property p_mode;
        @(posedge mclk) disable iff (reset) run && $past(run) |-> $stable(mode_ff);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed while running");
    property p_master_tx;
        @(posedge mclk) disable iff (reset) run && is_master && !wdog_rst |=> tx_drive == $past(aux_address_input);
    endproperty
    a_master_tx: assert property (p_master_tx) else $error("aux pin not driving transmitter");
endmodule : asi_node_core
`default_nettype wire

// file: asi_node_peer.sv
// far-side bus node model sending demodulated telegram bit streams
`timescale 1ns/1ps
`default_nettype none
module asi_node_peer
    import asi_node_pkg::*;
#(
    parameter int BIT_CYC = 600
) (
    // clock
    input wire logic mclk,
    // demodulated streams per channel
    output rx_bits_type bus_rx,
    output rx_bits_type aux_rx
);
    logic junk_ff = 1'h0;
    // bit value is meaningless between bit pulses, so keep it moving
    always @(posedge mclk) begin
        junk_ff <= ~junk_ff;
    end
    initial begin
        bus_rx = '0;
        aux_rx = '0;
    end
    task automatic put(input logic aux, input rx_bits_type v);
        if (aux) aux_rx <= v;
        else bus_rx <= v;
    endtask : put
    // first bit first, err_at picks a bit that carries a timing fault
    task automatic send(input logic aux, input logic [13:0] bits, input int n, input int err_at);
        int i;
        int c;
        for (i = 0; i < n; i++) begin
            for (c = 0; c < BIT_CYC; c++) begin
                @(posedge mclk);
                put(aux, '{c == 0, (c == 0) ? bits[n - 1 - i] : junk_ff, 1'h0, c == 1 && i == err_at});
            end
        end
        @(posedge mclk);
        put(aux, '{1'h0, junk_ff, 1'h1, 1'h0});
        @(posedge mclk);
        put(aux, '{1'h0, ~junk_ff, 1'h0, 1'h0});
    endtask : send
endmodule : asi_node_peer
`default_nettype wire

// file: asi_node_core_test.sv
// self-checking bench for the bus node core
`timescale 1ns/1ps
`default_nettype none
module asi_node_core_test;
    import asi_node_pkg::*;
    localparam int DET = 2000;
    localparam int HOT = 50;
    localparam int WDG = 300;
    typedef struct packed {
        logic mf;
        logic rf;
        logic [2:0] lvl;
        logic [1:0] mode;
        logic nvwe;
        logic fda;
        logic [2:0] thr;
    } row_type;
    row_type rows [8] = '{
        {1'h0, 1'h0, 3'h0, 2'h0, 1'h1, 1'h0, 3'h0},
        {1'h1, 1'h0, 3'h1, 2'h1, 1'h0, 1'h1, 3'h1},
        {1'h1, 1'h1, 3'h2, 2'h3, 1'h0, 1'h0, 3'h1},
        {1'h0, 1'h1, 3'h3, 2'h2, 1'h0, 1'h0, 3'h2},
        {1'h0, 1'h0, 3'h4, 2'h0, 1'h1, 1'h0, 3'h2},
        {1'h1, 1'h0, 3'h5, 2'h1, 1'h0, 1'h1, 3'h3},
        {1'h1, 1'h1, 3'h6, 2'h3, 1'h0, 1'h0, 3'h3},
        {1'h0, 1'h1, 3'h7, 2'h2, 1'h0, 1'h0, 3'h4}
    };
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic nv_master_flag = 1'h0;
    logic nv_repeater_flag = 1'h0;
    logic [2:0] adc_level = 3'h0;
    logic first_pulse = 1'h0;
    logic aux_address_input = 1'h0;
    logic xtal_tick = 1'h0;
    logic over_temp = 1'h0;
    logic load_short = 1'h0;
    logic [2:0] thr_pos, thr_neg;
    rx_bits_type bus_rx, aux_rx;
    logic tx_drive, tx_active, master_strobe, slave_strobe, freq_16mhz, freq_locked;
    logic device_reset, inductor_enable, analog_power_down, fail_detect_analog, nv_write_enable;
    int tick_per = 100;
    int tick_cnt = 0;
    int n_mstr = 0;
    int n_sstr = 0;
    int n_errors = 0;
    int n_checks = 0;
    asi_node_core #(.DETECT_CYC(DET), .HOT_CYC(HOT), .WDOG_CYC(WDG), .TICK_THR(15)) dut (
        .mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .nv_master_flag, .nv_repeater_flag, .adc_level, .first_pulse, .thr_pos, .thr_neg,
        .bus_rx, .aux_rx, .aux_address_input, .tx_drive, .tx_active, .master_strobe, .slave_strobe,
        .xtal_tick, .over_temp, .load_short, .freq_16mhz, .freq_locked, .device_reset,
        .inductor_enable, .analog_power_down, .fail_detect_analog, .nv_write_enable
    );
    asi_node_peer #(.BIT_CYC(40)) peer (.mclk, .bus_rx, .aux_rx);
    always #5 mclk = ~mclk;
    // divided crystal ticks, period 0 stops the oscillator
    always @(posedge mclk) begin
        tick_cnt <= (tick_cnt + 1 >= tick_per) ? 0 : tick_cnt + 1;
        xtal_tick <= tick_per != 0 && tick_cnt == 0;
        if (master_strobe === 1'h1) n_mstr <= n_mstr + 1;
        if (slave_strobe === 1'h1) n_sstr <= n_sstr + 1;
    end
    task automatic give_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int i;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'h1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            check("pready", pready, 1'h1);
            give_verdict();
        end
    endtask : apb
    task automatic power_on(input logic mf, input logic rf);
        @(posedge mclk);
        reset <= 1'h1;
        nv_master_flag <= mf;
        nv_repeater_flag <= rf;
        repeat (10) @(posedge mclk);
        reset <= 1'h0;
        repeat (3) @(posedge mclk);
    endtask : power_on
    function automatic logic [13:0] call_bits(input logic [10:0] d, input logic bad);
        return {1'h0, d, ^d ^ bad, 1'h1};
    endfunction : call_bits
    function automatic logic [13:0] resp_bits(input logic [3:0] d, input logic bad);
        return {8'h0, d, ^d ^ bad, 1'h1};
    endfunction : resp_bits
    initial begin
        int i;
        int h;
        int m0;
        int s0;
        logic [6:0] f;
        repeat (5) @(posedge mclk);
        check("rst_freq16", freq_16mhz, 1'h1);
        check("rst_lock", freq_locked, 1'h0);
        check("rst_thr", thr_pos, 3'h2);
        foreach (rows[r]) begin
            power_on(rows[r].mf, rows[r].rf);
            nv_master_flag <= ~rows[r].mf;
            nv_repeater_flag <= ~rows[r].rf;
            adc_level <= rows[r].lvl;
            first_pulse <= 1'h1;
            @(posedge mclk);
            first_pulse <= 1'h0;
            adc_level <= ~rows[r].lvl;
            apb(1'h0, 32'hC, 32'h0);
            check("thr_reg", rd[6:0], {rows[r].thr, 1'h0, rows[r].thr});
            check("thr_pos", thr_pos, rows[r].thr);
            check("thr_neg", thr_neg, rows[r].thr);
            apb(1'h0, 32'h0, 32'h0);
            check("mode", rd[1:0], rows[r].mode);
            check("nv_we", nv_write_enable, rows[r].nvwe);
            check("fid_analog", fail_detect_analog, rows[r].fda);
        end
        tick_per <= 200;
        power_on(1'h0, 1'h0);
        repeat (DET + 400) @(posedge mclk);
        check("freq_slow", freq_16mhz, 1'h0);
        peer.send(1'h0, call_bits(11'h5A5, 1'h1), 14, -1);
        peer.send(1'h0, call_bits(11'h5A5, 1'h0), 14, 3);
        repeat (3) @(posedge mclk);
        check("bad_calls", n_mstr, 0);
        check("no_lock", freq_locked, 1'h0);
        peer.send(1'h1, call_bits(11'h5A5, 1'h0), 14, -1);
        repeat (3) @(posedge mclk);
        check("good_call", n_mstr, 1);
        check("lock", freq_locked, 1'h1);
        apb(1'h0, 32'h4, 32'h0);
        check("rxdata", rd & 32'h187FF, 32'h185A5);
        apb(1'h0, 32'h0, 32'h0);
        check("reply_state", rd[7:6], 2'h1);
        apb(1'h1, 32'h8, 32'hA);
        check("resp_ok", err, 1'h0);
        for (i = 0; i < 100 && tx_active !== 1'h1; i++) @(posedge mclk);
        check("tx_start", tx_active, 1'h1);
        if (tx_active !== 1'h1) give_verdict();
        f = {1'h0, 4'hA, ^4'hA, 1'h1};
        for (h = 0; h < 14; h++) begin
            repeat (150) @(posedge mclk);
            check("tx_half", tx_drive, f[6 - h / 2] ^ (h % 2 == 0));
            repeat (150) @(posedge mclk);
        end
        repeat (20) @(posedge mclk);
        check("tx_idle", tx_drive, 1'h0);
        tick_per <= 100;
        repeat (2 * DET + 200) @(posedge mclk);
        check("freq_frozen", freq_16mhz, 1'h0);
        tick_per <= 0;
        repeat (WDG + 100) @(posedge mclk);
        check("wdog_reset", device_reset, 1'h1);
        tick_per <= 100;
        repeat (250) @(posedge mclk);
        check("wdog_free", device_reset, 1'h0);
        check("lock_kept", freq_locked, 1'h1);
        check("freq_kept", freq_16mhz, 1'h0);
        power_on(1'h0, 1'h0);
        check("por_unlock", freq_locked, 1'h0);
        check("por_freq", freq_16mhz, 1'h1);
        power_on(1'h1, 1'h0);
        m0 = n_mstr;
        s0 = n_sstr;
        for (i = 0; i < 4; i++) begin
            aux_address_input <= i[0];
            repeat (3) @(posedge mclk);
            check("tx_copy", tx_drive, i[0]);
        end
        peer.send(1'h0, call_bits(11'h3C3, 1'h0), 14, -1);
        peer.send(1'h0, resp_bits(4'h6, 1'h1), 7, -1);
        peer.send(1'h0, resp_bits(4'h6, 1'h0), 7, -1);
        repeat (3) @(posedge mclk);
        check("mst_calls", n_mstr - m0, 0);
        check("mst_resp", n_sstr - s0, 1);
        check("mst_lock", freq_locked, 1'h1);
        apb(1'h1, 32'h8, 32'h5);
        check("resp_refused", err, 1'h1);
        apb(1'h0, 32'h10, 32'h0);
        check("unmapped", err, 1'h1);
        power_on(1'h0, 1'h1);
        m0 = n_mstr;
        s0 = n_sstr;
        peer.send(1'h0, call_bits(11'h7FF, 1'h0), 14, -1);
        peer.send(1'h0, resp_bits(4'hF, 1'h0), 7, -1);
        repeat (3) @(posedge mclk);
        check("mon_call", n_mstr - m0, 1);
        check("mon_resp", n_sstr - s0, 1);
        for (i = 0; i < 2; i++) begin
            power_on(1'h0, 1'h0);
            {over_temp, load_short} <= i[0] ? 2'h1 : 2'h2;
            repeat (HOT - 10) @(posedge mclk);
            {over_temp, load_short} <= 2'h0;
            @(posedge mclk);
            check("brief_hot", inductor_enable, 1'h1);
            {over_temp, load_short} <= i[0] ? 2'h1 : 2'h2;
            repeat (HOT + 10) @(posedge mclk);
            {over_temp, load_short} <= 2'h0;
            repeat (20) @(posedge mclk);
            check("ind_off", inductor_enable, 1'h0);
            check("pwr_down", analog_power_down, 1'h1);
            check("sd_reset", device_reset, 1'h1);
        end
        power_on(1'h0, 1'h0);
        check("sd_clear", inductor_enable, 1'h1);
        give_verdict();
    end
endmodule : asi_node_core_test
`default_nettype wire
